// ---- hw/ssr_link.sv ----
// Serial-clock side shifter that captures the data line on each clock rise.
`timescale 1ns/1ps

module ssr_link (
   // Serial clock domain
   input wire logic scl,
   input wire logic sda_in,
   // Last eight bits seen, newest in bit 0
   output logic [ssr_pkg::BITS_PER_BYTE-1:0] rx_byte
);
   import ssr_pkg::*;

   typedef struct packed {
      logic [BITS_PER_BYTE-1:0] shift;
   } ssr_link_st_t;

   ssr_link_st_t q;
   ssr_link_st_t d;

   // ------------------------------------------------------------
   // Shifter
   // ------------------------------------------------------------
   // No reset: the serial clock may stand still during reset, and the
   // byte is only read after the system side has seen eight rises.
   always_comb
   begin
      d = q;
      d.shift = {q.shift[BITS_PER_BYTE-2:0], sda_in};
   end

   always_ff @(posedge scl)
   begin
      q <= d;
   end

   assign rx_byte = q.shift;

endmodule

// ---- hw/ssr_pkg.sv ----
// Shared constants and types of the two-wire slave register access block.
package ssr_pkg;

   // ------------------------------------------------------------
   // Bus addressing
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_FIXED = 4'h3;
   localparam int ADDR_SEL_W = 3;
   localparam int BITS_PER_BYTE = 8;
   localparam logic [1:0] VALID_LATCH = 2'h1;
   localparam logic [1:0] VALID_MAX = 2'h2;

   // ------------------------------------------------------------
   // Register side
   // ------------------------------------------------------------
   localparam int PTR_W = 8;
   localparam int DATA_W = 16;
   localparam int NREG = 16;
   localparam logic [7:0] PTR_RESET = 8'h00;

   // Position of a byte within one write or read transfer.
   localparam logic [2:0] BYTE_ADDR = 3'h0;
   localparam logic [2:0] BYTE_PTR = 3'h1;
   localparam logic [2:0] BYTE_MSB = 3'h2;
   localparam logic [2:0] BYTE_LSB = 3'h3;
   localparam logic [2:0] BYTE_EXTRA = 3'h4;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_FREQ_KHZ = 100000;
   localparam int TIMEOUT_MIN_MS = 75;
   localparam int CONV_MS = 100;
   localparam int TIMEOUT_CYCLES = TIMEOUT_MIN_MS * CLK_FREQ_KHZ;
   localparam int CONV_CYCLES = CONV_MS * CLK_FREQ_KHZ;
   localparam int TO_W = 24;

   // ------------------------------------------------------------
   // Slave sequencer states
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RX = 5'h02,
      ST_ACK = 5'h04,
      ST_TX = 5'h08,
      ST_MACK = 5'h10
   } ssr_state_t;

endpackage

// ---- hw/ssr_slave.sv ----
// Two-wire slave front end: address match, register select and 16-bit access.
`timescale 1ns/1ps

// Notes on behaviour
// - Answer address 0011 plus three pin bits.
// - Pins give eight addresses 0x18 to 0x1F.
// - Release data line after 75 ms silence.
// - Pull data low before ninth pulse on match.
// - Direction 0 writes, 1 reads.
// - Nine pulses per byte, receiver acknowledges.
// - Data changes only while clock low; stop.
// - Direction fixed until a new start.
// - Latch pin address at second valid access.
// - Register select resets to 0x00, retained.
// - Registers are read, write or both.
// - Read uses stored select or repeated start.
// - MSB first; accept ack or no-ack.
// - New reading every 100 ms.
// - Data registers 16 bits; extras ignored.
module ssr_slave #(
   parameter int TIMEOUT_CYCLES = ssr_pkg::TIMEOUT_CYCLES,
   parameter int CONV_CYCLES = ssr_pkg::CONV_CYCLES,
   parameter logic [ssr_pkg::NREG-1:0] READABLE = '1,
   parameter logic [ssr_pkg::NREG-1:0] WRITABLE = '1
) (
   // System clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // Serial bus, open drain data line
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // Address select pins
   input wire logic ADDR_SELECT_BIT0,
   input wire logic ADDR_SELECT_BIT1,
   input wire logic ADDR_SELECT_BIT2,
   // Data register port
   output logic [ssr_pkg::PTR_W-1:0] REG_INDEX,
   output logic [ssr_pkg::DATA_W-1:0] REG_WDATA,
   output logic REG_WR_STROBE,
   input wire logic [ssr_pkg::DATA_W-1:0] REG_RDATA,
   // Status
   output logic ADDR_LOCKED,
   output logic CONV_TICK
);
   import ssr_pkg::*;

   localparam int IDX_W = $clog2(NREG);

   typedef struct packed {
      logic scl_m, scl_s, scl_p;
      logic sda_m, sda_s, sda_p;
      logic [ADDR_SEL_W-1:0] sel_m, sel_s;
      ssr_state_t st;
      logic [3:0] cnt;
      logic [2:0] byte_idx;
      logic rw, ack_seen, mack, rd_lo;
      logic [BITS_PER_BYTE-1:0] hi, tx;
      logic [DATA_W-1:0] rdata;
      logic [PTR_W-1:0] ptr;
      logic [DATA_W-1:0] wdata;
      logic wr, oe, sda_out;
      logic [1:0] valid_cnt;
      logic locked;
      logic [ADDR_SEL_W-1:0] lock_addr;
      logic [TO_W-1:0] to_cnt, conv_cnt;
      logic conv_tick;
   } ssr_st_t;

   // Line synchronisers start at the idle bus level, so no false edge follows reset.
   localparam ssr_st_t ST_RESET = '{st: ST_IDLE, ptr: PTR_RESET, scl_m: 1'b1, scl_s: 1'b1,
      scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1, default: '0};

   ssr_st_t q;
   ssr_st_t d;

   logic [BITS_PER_BYTE-1:0] rx_byte;
   logic scl_rise, scl_fall;
   logic start_ev, stop_ev;
   logic timed_out, quiet;
   logic rx_done, addr_hit;
   logic [ADDR_SEL_W-1:0] cur_addr;
   logic [BITS_PER_BYTE-1:0] nxt_byte;

   function automatic logic in_map(input logic [NREG-1:0] m, input logic [PTR_W-1:0] i);
      return (int'(i) < NREG) ? m[i[IDX_W-1:0]] : 1'b0;
   endfunction

   // ------------------------------------------------------------
   // Link side capture
   // ------------------------------------------------------------
   // The byte shifted on the serial clock is read only after the
   // synchronised clock rise, by which time it has long settled.
   ssr_link u_link (
      .scl(SCL),
      .sda_in(SDA_IN),
      .rx_byte(rx_byte)
   );

   // ------------------------------------------------------------
   // Bus events
   // ------------------------------------------------------------
   assign scl_rise = q.scl_s & ~q.scl_p;
   assign scl_fall = ~q.scl_s & q.scl_p;
   assign start_ev = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
   assign stop_ev = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
   assign timed_out = (q.st != ST_IDLE) && (q.to_cnt >= TO_W'(TIMEOUT_CYCLES));
   assign quiet = ~start_ev & ~stop_ev & ~timed_out;
   assign rx_done = (q.st == ST_RX) && scl_rise && (q.cnt == 4'h7);
   // Pins steer the address live until the lock is taken.
   assign cur_addr = q.locked ? q.lock_addr : q.sel_s;
   assign addr_hit = (rx_byte[7:1] == {ADDR_FIXED, cur_addr});
   assign nxt_byte = q.rd_lo ? q.rdata[7:0] : q.rdata[15:8];

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      d = q;
      d.scl_m = SCL;
      d.scl_s = q.scl_m;
      d.scl_p = q.scl_s;
      d.sda_m = SDA_IN;
      d.sda_s = q.sda_m;
      d.sda_p = q.sda_s;
      d.sel_m = {ADDR_SELECT_BIT2, ADDR_SELECT_BIT1, ADDR_SELECT_BIT0};
      d.sel_s = q.sel_m;
      d.wr = 1'b0;
      d.conv_tick = 1'b0;
      // Silence is measured on the data line alone.
      if (q.sda_s != q.sda_p)
      begin
         d.to_cnt = '0;
      end
      else if (q.to_cnt != '1)
      begin
         d.to_cnt = q.to_cnt + TO_W'(1);
      end
      // Conversion pacing.
      if (q.conv_cnt == TO_W'(CONV_CYCLES - 1))
      begin
         d.conv_cnt = '0;
         d.conv_tick = 1'b1;
      end
      else
      begin
         d.conv_cnt = q.conv_cnt + TO_W'(1);
      end
      if (start_ev)
      begin
         // A repeated start also lands here, so direction is taken anew.
         d.st = ST_RX;
         d.cnt = 4'h0;
         d.byte_idx = BYTE_ADDR;
         d.oe = 1'b0;
      end
      else if (stop_ev || timed_out)
      begin
         d.st = ST_IDLE;
         d.oe = 1'b0;
      end
      else
      begin
         case (q.st)
            ST_IDLE:
            begin
               d.oe = 1'b0;
            end
            ST_RX:
            begin
               if (scl_rise)
               begin
                  d.cnt = q.cnt + 4'h1;
               end
               if (rx_done && q.byte_idx == BYTE_ADDR)
               begin
                  if (addr_hit)
                  begin
                     d.st = ST_ACK;
                     d.ack_seen = 1'b0;
                     d.rw = rx_byte[0];
                     d.rd_lo = 1'b0;
                     d.rdata = in_map(READABLE, q.ptr) ? REG_RDATA : '0;
                     if (q.valid_cnt != VALID_MAX)
                     begin
                        d.valid_cnt = q.valid_cnt + 2'h1;
                     end
                     if (q.valid_cnt == VALID_LATCH && !q.locked)
                     begin
                        d.locked = 1'b1;
                        d.lock_addr = q.sel_s;
                     end
                  end
                  else
                  begin
                     d.st = ST_IDLE;
                  end
               end
               else if (rx_done)
               begin
                  d.st = ST_ACK;
                  d.ack_seen = 1'b0;
                  if (q.byte_idx == BYTE_PTR)
                  begin
                     d.ptr = rx_byte;
                  end
                  else if (q.byte_idx == BYTE_MSB)
                  begin
                     d.hi = rx_byte;
                  end
                  else if (q.byte_idx == BYTE_LSB && in_map(WRITABLE, q.ptr))
                  begin
                     d.wdata = {q.hi, rx_byte};
                     d.wr = 1'b1;
                  end
               end
            end
            ST_ACK:
            begin
               if (scl_rise)
               begin
                  d.ack_seen = 1'b1;
               end
               if (scl_fall && !q.ack_seen)
               begin
                  d.oe = 1'b1;
               end
               else if (scl_fall)
               begin
                  d.cnt = 4'h0;
                  if (q.byte_idx != BYTE_EXTRA)
                  begin
                     d.byte_idx = q.byte_idx + 3'h1;
                  end
                  if (q.rw)
                  begin
                     d.st = ST_TX;
                     d.oe = ~nxt_byte[7];
                     d.tx = {nxt_byte[6:0], 1'b0};
                     d.rd_lo = ~q.rd_lo;
                  end
                  else
                  begin
                     d.st = ST_RX;
                     d.oe = 1'b0;
                  end
               end
            end
            ST_TX:
            begin
               if (scl_rise)
               begin
                  d.cnt = q.cnt + 4'h1;
               end
               if (scl_fall && q.cnt == 4'h8)
               begin
                  d.oe = 1'b0;
                  d.st = ST_MACK;
                  d.ack_seen = 1'b0;
               end
               else if (scl_fall)
               begin
                  d.oe = ~q.tx[7];
                  d.tx = {q.tx[6:0], 1'b0};
               end
            end
            ST_MACK:
            begin
               if (scl_rise)
               begin
                  d.ack_seen = 1'b1;
                  d.mack = ~rx_byte[0];
               end
               if (scl_fall && q.ack_seen && q.mack)
               begin
                  d.st = ST_TX;
                  d.cnt = 4'h0;
                  d.oe = ~nxt_byte[7];
                  d.tx = {nxt_byte[6:0], 1'b0};
                  d.rd_lo = ~q.rd_lo;
               end
               else if (scl_fall && q.ack_seen)
               begin
                  d.st = ST_IDLE;
               end
            end
            default:
            begin
               d.st = ST_IDLE;
               d.oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         q <= ST_RESET;
      end
      else
      begin
         q <= d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // The data line is open drain: only the enable moves.
   assign SDA_OUT = q.sda_out;
   assign SDA_OE = q.oe;
   assign REG_INDEX = q.ptr;
   assign REG_WDATA = q.wdata;
   assign REG_WR_STROBE = q.wr;
   assign ADDR_LOCKED = q.locked;
   assign CONV_TICK = q.conv_tick;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   sequence seq_released;
      !SDA_OE && q.st == ST_IDLE;
   endsequence
   sequence seq_foreign_addr;
      rx_done && q.byte_idx == BYTE_ADDR && !addr_hit && quiet;
   endsequence

   AST_SELECT_RESET: assert property ($past(RESET_N) == 1'b0 |-> REG_INDEX == PTR_RESET)
      else $error("register select not cleared by reset");
   AST_STOP_RELEASE: assert property (stop_ev |=> seq_released)
      else $error("data line not released after stop");
   AST_TIMEOUT: assert property (timed_out && !start_ev |=> seq_released)
      else $error("data line not released after timeout");
   AST_FOREIGN: assert property (seq_foreign_addr |=> seq_released)
      else $error("foreign address not ignored");
   AST_ACK_DRIVE: assert property (q.st == ST_ACK && scl_fall && !q.ack_seen && quiet |=> SDA_OE)
      else $error("acknowledge not driven");
   AST_LOCK_SECOND: assert property ($rose(q.locked) |-> $past(q.valid_cnt) == VALID_LATCH)
      else $error("address locked at wrong access");
   AST_LOCK_HOLD: assert property (q.locked |=> q.locked && $stable(q.lock_addr))
      else $error("locked address changed");
   AST_WR_PLACE: assert property (REG_WR_STROBE |-> !q.rw && q.st == ST_ACK && q.byte_idx == BYTE_LSB)
      else $error("write strobe outside second data byte");
   AST_WR_KIND: assert property (REG_WR_STROBE |-> in_map(WRITABLE, REG_INDEX))
      else $error("write to a register that cannot be written");
   AST_DIR_FIXED: assert property (q.byte_idx != BYTE_ADDR |=> $stable(q.rw))
      else $error("direction changed inside a transfer");
   AST_MSB_FIRST: assert property (q.st == ST_TX && scl_fall && q.cnt != 4'h8 && quiet
      |=> SDA_OE == !$past(q.tx[7]))
      else $error("transmit bit order wrong");
   AST_TICK_GAP: assert property (CONV_TICK |=> !CONV_TICK [*8])
      else $error("conversion ticks too close");

endmodule

// ---- tb/ssr_master.sv ----
// Behavioural two-wire bus master that drives the serial clock and pulls the data line.
`timescale 1ns/1ps

module ssr_master (
   // Serial clock, idle high between frames
   output logic scl = 1'b1,
   // Data line: pull low while high, wire level seen back
   output logic sda_pull = 1'b0,
   input wire logic sda
);
   // Added to the first three phases of a bit and the first phase of start and stop; a large value makes a slow master.
   int extra = 0;

   // ------------------------------------------------------------
   // Bit and byte level
   // ------------------------------------------------------------
   // Data moves 20 ns into the low phase, so both synchronisers in the slave see the
   // clock fall first. Sampling late in the high phase leaves room for the slave's
   // three-cycle answer.
   task automatic bit_io(input logic b, output logic r);
      #(20 + extra) sda_pull = !b;
      #(20 + extra) scl = 1'b1;
      #(30 + extra) r = sda;
      #10 scl = 1'b0;
   endtask

   task automatic start();
      #(20 + extra) sda_pull = 1'b0;
      #20 scl = 1'b1;
      #40 sda_pull = 1'b1;
      #40 scl = 1'b0;
   endtask

   task automatic stop();
      #(20 + extra) sda_pull = 1'b1;
      #20 scl = 1'b1;
      #40 sda_pull = 1'b0;
      #40;
   endtask

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask

   // The last byte of a read is answered with a released line.
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask
endmodule

// ---- tb/ssr_slave_bench.sv ----
// Self-checking bench of the two-wire slave register access block.
`timescale 1ns/1ps

module ssr_slave_bench;
   import ssr_pkg::*;
   localparam int TO_SIM = 2000;
   localparam int TO_MAX = TO_SIM * 100 / 75 + 1;
   localparam int CONV_SIM = 20;
   logic CLK = 1'b0;
   logic RESET_N = 1'b0;
   logic [2:0] pins = 3'h0;
   logic [15:0] regs [16];
   logic [15:0] last_wdata = 16'h0;
   int strobes = 0;
   int tick_gap = -1;
   int num_errors = 0;
   int cmp_count = 0;
   wire scl;
   wire m_pull;
   wire sda_out;
   wire sda_oe;
   wire sda = !(sda_oe | m_pull);
   wire [7:0] reg_index;
   wire [15:0] reg_wdata;
   wire wr_strobe;
   wire addr_locked;
   wire conv_tick;

   always #5 CLK = ~CLK;

   // Index 1 is read only and index 2 write only.
   ssr_slave #(.TIMEOUT_CYCLES(TO_SIM), .CONV_CYCLES(CONV_SIM), .READABLE(16'hfffb),
      .WRITABLE(16'hfffd)) u_ssr_slave (.CLK(CLK), .RESET_N(RESET_N), .SCL(scl),
      .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SELECT_BIT0(pins[0]),
      .ADDR_SELECT_BIT1(pins[1]), .ADDR_SELECT_BIT2(pins[2]), .REG_INDEX(reg_index),
      .REG_WDATA(reg_wdata), .REG_WR_STROBE(wr_strobe), .REG_RDATA(regs[reg_index[3:0]]),
      .ADDR_LOCKED(addr_locked), .CONV_TICK(conv_tick));

   ssr_master u_ssr_master (.scl(scl), .sda_pull(m_pull), .sda(sda));

   // ------------------------------------------------------------
   // Checking and user register file
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   always @(posedge CLK)
   begin
      if (wr_strobe === 1'b1)
      begin
         strobes++;
         last_wdata = reg_wdata;
         regs[reg_index[3:0]] <= reg_wdata;
      end
      if (!RESET_N)
         tick_gap = -1;
      else if (conv_tick === 1'b1)
      begin
         if (tick_gap >= 0)
            chk(16'(tick_gap), 16'(CONV_SIM - 1));
         tick_gap = 0;
      end
      else if (tick_gap >= 0)
         tick_gap++;
   end

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic do_reset();
      @(posedge CLK);
      #1 RESET_N = 1'b0;
      repeat (10) @(posedge CLK);
      #1 RESET_N = 1'b1;
      repeat (4) @(posedge CLK);
   endtask

   task automatic set_pins(input logic [2:0] v);
      @(posedge CLK);
      #1 pins = v;
      repeat (3) @(posedge CLK);
   endtask

   task automatic wr_reg(input logic [6:0] a, input logic [7:0] p, input int nd,
      input logic [15:0] d, output logic ok);
      logic ack;
      // Bus edges then fall 1 ns after a system clock edge, never on it.
      @(posedge CLK);
      #1;
      u_ssr_master.start();
      u_ssr_master.wr_byte({a, 1'b0}, ok);
      if (ok)
      begin
         u_ssr_master.wr_byte(p, ack);
         chk({15'h0, ack}, 16'h1);
         for (int i = 0; i < nd; i++)
         begin
            u_ssr_master.wr_byte(i[0] ? d[7:0] : d[15:8], ack);
            chk({15'h0, ack}, 16'h1);
         end
      end
      u_ssr_master.stop();
   endtask

   task automatic rd_reg(input logic [6:0] a, input logic setp, input logic [7:0] p,
      input int nb, output logic [23:0] d);
      logic ack;
      logic [7:0] b;
      d = 24'h0;
      @(posedge CLK);
      #1;
      u_ssr_master.start();
      if (setp)
      begin
         u_ssr_master.wr_byte({a, 1'b0}, ack);
         u_ssr_master.wr_byte(p, ack);
         chk({15'h0, ack}, 16'h1);
         u_ssr_master.start();
      end
      u_ssr_master.wr_byte({a, 1'b1}, ack);
      chk({15'h0, ack}, 16'h1);
      for (int i = 0; i < nb; i++)
      begin
         u_ssr_master.rd_byte(i == nb - 1, b);
         d = {d[15:0], b};
      end
      u_ssr_master.stop();
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      logic ok;
      logic [23:0] rd;
      for (int i = 0; i < 16; i++)
         regs[i] = 16'(i * 16'h1111);
      do_reset();
      chk({8'h0, reg_index}, 16'h0);
      chk({15'h0, sda_out}, 16'h0);
      for (int k = 0; k < 8; k++)
      begin
         do_reset();
         set_pins(3'(k));
         wr_reg({4'h2, 3'(k)}, 8'h0, 0, 16'h0, ok);
         chk({15'h0, ok}, 16'h0);
         wr_reg(7'h18 + 7'(k), 8'h0, 0, 16'h0, ok);
         chk({15'h0, ok}, 16'h1);
      end
      chk({15'h0, addr_locked}, 16'h0);
      set_pins(3'h2);
      wr_reg(7'h1a, 8'h0, 0, 16'h0, ok);
      chk({15'h0, addr_locked}, 16'h1);
      set_pins(3'h5);
      wr_reg(7'h1d, 8'h0, 0, 16'h0, ok);
      chk({15'h0, ok}, 16'h0);
      strobes = 0;
      wr_reg(7'h1a, 8'h05, 3, 16'h1234, ok);
      chk(16'(strobes), 16'h1);
      chk(last_wdata, 16'h1234);
      chk({8'h0, reg_index}, 16'h0005);
      rd_reg(7'h1a, 1'b0, 8'h0, 2, rd);
      chk(rd[15:0], 16'h1234);
      chk({8'h0, reg_index}, 16'h0005);
      wr_reg(7'h1a, 8'h07, 2, 16'ha5c3, ok);
      rd_reg(7'h1a, 1'b1, 8'h07, 3, rd);
      chk(rd[23:8], 16'ha5c3);
      chk({8'h0, rd[7:0]}, 16'h00a5);
      strobes = 0;
      wr_reg(7'h1a, 8'h01, 2, 16'h4242, ok);
      chk(16'(strobes), 16'h0);
      rd_reg(7'h1a, 1'b1, 8'h02, 2, rd);
      chk(rd[15:0], 16'h0);
      // The unreadable index returns zero, so the slave holds the line low and stalls.
      u_ssr_master.start();
      u_ssr_master.wr_byte({7'h1a, 1'b1}, ok);
      repeat (1500) @(posedge CLK);
      #1;
      chk({15'h0, sda_oe}, 16'h1);
      chk({15'h0, sda_out}, 16'h0);
      repeat (TO_MAX - 1500) @(posedge CLK);
      #1;
      chk({15'h0, sda_oe}, 16'h0);
      u_ssr_master.stop();
      u_ssr_master.extra = 200;
      rd_reg(7'h1a, 1'b1, 8'h05, 2, rd);
      chk(rd[15:0], 16'h1234);
      close_out();
   end

   initial
   begin
      #500000;
      num_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      close_out();
   end
endmodule
